//--- rtl/async_serial_control_regs.sv
// Serial control registers with transmitter, receiver and interrupt request logic
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module async_serial_control_regs
  import serial_ctrl_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_CYCLES_DEF
)(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        serialInPin,
  output logic             serialOutPin,
  output logic             txIrq,
  output logic             rxIrq,
  output logic             errIrq
);

  localparam logic [15:0] LAST_TICK = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] MID_TICK  = 16'(BIT_CYCLES / 2);

  logic [7:0]  ctrlOne_q;
  logic        txEmptyIrqEn_q, txDoneIrqEn_q, rxFullIrqEn_q, quietIrqEn_q;
  logic        txOn_q, rxOn_q, rxStandby_q, breakSend_q;
  logic        txNinth_q, rxNinth_q;
  logic [3:0]  errIrqEn_q;
  logic [7:0]  txBuf_q, rxData_q;
  logic        txEmpty_q, txDone_q, rxFull_q, quiet_q, overrun_q, noise_q, frameErr_q, parityErr_q;
  logic        statusSeen_q, ack_q, txIrq_q, rxIrq_q, errIrq_q, serialOut_q, txOnPrev_q;
  logic [31:0] datOut_q;
  logic        busReq, busWr, busRd, wrOne, wrTwo, wrThree, wrData, rdStatus, rdData;
  logic        moduleOn, charNine, rouseSel, idleAfterStop, parityOn, oddParity;
  logic [3:0]  charLen;

  assign moduleOn      = ctrlOne_q[C1_MODULE_ON];
  assign charNine      = ctrlOne_q[C1_CHAR_NINE];
  assign rouseSel      = ctrlOne_q[C1_ROUSE_SEL];
  assign idleAfterStop = ctrlOne_q[C1_IDLE_SEL];
  assign parityOn      = ctrlOne_q[C1_PARITY_ON];
  assign oddParity     = ctrlOne_q[C1_ODD_PAR];
  assign charLen       = charNine ? LEN_NINE : LEN_EIGHT;

  // Bus decode: one request per ack, byte lane 0 carries the registers
  assign busReq   = wb_cyc_i & wb_stb_i & ~ack_q;
  assign busWr    = busReq & wb_we_i & wb_sel_i[0];
  assign busRd    = busReq & ~wb_we_i;
  assign wrOne    = busWr & (wb_adr_i == ADDR_CTRL_ONE);
  assign wrTwo    = busWr & (wb_adr_i == ADDR_CTRL_TWO);
  assign wrThree  = busWr & (wb_adr_i == ADDR_CTRL_THREE);
  assign wrData   = busWr & (wb_adr_i == ADDR_DATA);
  assign rdStatus = busRd & (wb_adr_i == ADDR_STATUS);
  assign rdData   = busRd & (wb_adr_i == ADDR_DATA);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q    <= 1'b0;
      datOut_q <= 32'h0000_0000;
    end else begin
      ack_q <= busReq;
      if (busRd) begin
        case (wb_adr_i)
          ADDR_CTRL_ONE:   datOut_q <= {24'h00_0000, 1'b0, ctrlOne_q[6], 1'b0, ctrlOne_q[4:0]};
          ADDR_CTRL_TWO:   datOut_q <= {24'h00_0000, txEmptyIrqEn_q, txDoneIrqEn_q, rxFullIrqEn_q,
                                        quietIrqEn_q, txOn_q, rxOn_q, rxStandby_q, breakSend_q};
          ADDR_CTRL_THREE: datOut_q <= {24'h00_0000, rxNinth_q, txNinth_q, 2'h0, errIrqEn_q};
          ADDR_STATUS:     datOut_q <= {24'h00_0000, txEmpty_q, txDone_q, rxFull_q, quiet_q,
                                        overrun_q, noise_q, frameErr_q, parityErr_q};
          ADDR_DATA:       datOut_q <= {24'h00_0000, rxData_q};
          default:         datOut_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control registers
  logic wakeEvent;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrlOne_q <= CTRL_RESET;
    end else if (wrOne) begin
      ctrlOne_q <= wb_dat_i[7:0] & 8'h5F;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {txEmptyIrqEn_q, txDoneIrqEn_q, rxFullIrqEn_q, quietIrqEn_q} <= 4'h0;
      {txOn_q, rxOn_q, rxStandby_q, breakSend_q}                   <= 4'h0;
    end else begin
      if (wakeEvent) begin
        rxStandby_q <= 1'b0;
      end
      if (wrTwo) begin
        txEmptyIrqEn_q <= wb_dat_i[C2_TXE_IE];
        txDoneIrqEn_q  <= wb_dat_i[C2_TXD_IE];
        rxFullIrqEn_q  <= wb_dat_i[C2_RXF_IE];
        quietIrqEn_q   <= wb_dat_i[C2_QUIET_IE];
        rxStandby_q    <= wb_dat_i[C2_STANDBY];
        breakSend_q    <= wb_dat_i[C2_BREAK];
        if (moduleOn) begin
          txOn_q <= wb_dat_i[C2_TX_ON];
          rxOn_q <= wb_dat_i[C2_RX_ON];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      errIrqEn_q <= 4'h0;
    end else if (wrThree) begin
      errIrqEn_q <= wb_dat_i[3:0];
    end
  end

  // Data held across reset
  always_ff @(posedge clk) begin
    if (wrThree) begin
      txNinth_q <= wb_dat_i[C3_TX_NINTH];
    end
    if (wrData) begin
      txBuf_q <= wb_dat_i[7:0];
    end
  end

  // Transmitter
  txState_e    txState_q;
  logic [10:0] txShift_q, txFrame;
  logic [3:0]  txBitsLeft_q;
  logic [15:0] txTimer_q;
  logic        txIsBreak_q, txIsPre_q, prePend_q;
  logic        txLoadBreak, txLoadPre, txLoadData, txBitEnd;
  logic [8:0]  txPay;

  always_comb begin
    txPay = {txNinth_q, txBuf_q};
    if (parityOn && charNine) begin
      txPay[8] = (^txBuf_q) ^ oddParity;
    end else if (parityOn) begin
      txPay[7] = (^txBuf_q[6:0]) ^ oddParity;
    end
    txFrame = charNine ? {1'b1, txPay, 1'b0} : {2'h3, txPay[7:0], 1'b0};
  end

  assign txLoadBreak = (txState_q == TX_IDLE) & moduleOn & txOn_q & breakSend_q;
  assign txLoadPre   = (txState_q == TX_IDLE) & moduleOn & ~breakSend_q & prePend_q;
  assign txLoadData  = (txState_q == TX_IDLE) & moduleOn & txOn_q & ~breakSend_q & ~prePend_q & ~txEmpty_q;
  assign txBitEnd    = (txTimer_q == LAST_TICK);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txOnPrev_q <= 1'b0;
      prePend_q  <= 1'b0;
    end else begin
      txOnPrev_q <= txOn_q;
      if (txLoadPre || txLoadBreak) begin
        prePend_q <= 1'b0;
      end
      if (txOn_q && !txOnPrev_q && !txLoadBreak) begin
        prePend_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txState_q    <= TX_IDLE;
      txShift_q    <= FRAME_ONES;
      txBitsLeft_q <= 4'h0;
      txTimer_q    <= 16'h0000;
      txIsBreak_q  <= 1'b0;
      txIsPre_q    <= 1'b0;
    end else begin
      case (txState_q)
        TX_IDLE: begin
          txTimer_q    <= 16'h0000;
          txBitsLeft_q <= charLen;
          txIsBreak_q  <= txLoadBreak;
          txIsPre_q    <= txLoadPre;
          if (txLoadBreak) begin
            txShift_q <= FRAME_ZEROS;
            txState_q <= TX_SHIFT;
          end else if (txLoadPre) begin
            txShift_q <= FRAME_ONES;
            txState_q <= TX_SHIFT;
          end else if (txLoadData) begin
            txShift_q <= txFrame;
            txState_q <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          txTimer_q <= txBitEnd ? 16'h0000 : txTimer_q + 16'h0001;
          if (txBitEnd) begin
            txShift_q    <= {1'b1, txShift_q[10:1]};
            txBitsLeft_q <= txBitsLeft_q - 4'h1;
            if (txBitsLeft_q == 4'h1) begin
              if (txIsBreak_q && breakSend_q && txOn_q && moduleOn) begin
                txShift_q    <= FRAME_ZEROS;
                txBitsLeft_q <= charLen;
              end else if (txIsBreak_q) begin
                txState_q <= TX_MARK;
              end else begin
                txState_q <= TX_IDLE;
              end
            end
          end
        end
        TX_MARK: begin
          txTimer_q <= txBitEnd ? 16'h0000 : txTimer_q + 16'h0001;
          if (txBitEnd) begin
            txState_q <= TX_IDLE;
          end
        end
        default: txState_q <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serialOut_q <= 1'b1;
    end else begin
      serialOut_q <= (txState_q == TX_SHIFT) ? txShift_q[0] : 1'b1;
    end
  end

  // Receiver with two-flop input synchroniser
  rxState_e    rxState_q;
  logic        rxMeta_q, rxSync_q, rxPrev_q, rxNoiseSeen_q;
  logic [2:0]  rxVote_q;
  logic [10:0] rxShift_q, rxShiftNext;
  logic [3:0]  rxBitIdx_q, quietCnt_q;
  logic [15:0] rxTimer_q, quietTimer_q;
  logic        rxBit, rxNoisy, rxDone, rxActive, quietHit, topBit, parErr;
  logic [8:0]  rxWord;

  assign rxActive    = rxOn_q & moduleOn;
  assign rxBit       = (rxVote_q[0] & rxVote_q[1]) | (rxVote_q[0] & rxVote_q[2]) | (rxVote_q[1] & rxVote_q[2]);
  assign rxNoisy     = ~(&rxVote_q) & (|rxVote_q);
  assign rxShiftNext = {rxBit, rxShift_q[10:1]};
  assign rxDone      = (rxState_q == RX_BITS) & (rxTimer_q == LAST_TICK) & (rxBitIdx_q == charLen - 4'h1);
  assign rxWord      = charNine ? rxShiftNext[9:1] : {1'b0, rxShiftNext[9:2]};
  assign topBit      = charNine ? rxWord[8] : rxWord[7];
  assign parErr      = parityOn & ((^rxWord) != oddParity);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
      rxPrev_q <= 1'b1;
    end else begin
      rxMeta_q <= serialInPin;
      rxSync_q <= rxMeta_q;
      rxPrev_q <= rxSync_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxState_q     <= RX_IDLE;
      rxTimer_q     <= 16'h0000;
      rxBitIdx_q    <= 4'h0;
      rxVote_q      <= 3'h7;
      rxShift_q     <= FRAME_ONES;
      rxNoiseSeen_q <= 1'b0;
    end else begin
      case (rxState_q)
        RX_IDLE: begin
          rxTimer_q     <= 16'h0000;
          rxBitIdx_q    <= 4'h0;
          rxNoiseSeen_q <= 1'b0;
          if (rxActive && rxPrev_q && !rxSync_q) begin
            rxState_q <= RX_BITS;
          end
        end
        RX_BITS: begin
          if (rxTimer_q >= MID_TICK - 16'h0001 && rxTimer_q <= MID_TICK + 16'h0001) begin
            rxVote_q <= {rxSync_q, rxVote_q[2:1]};
          end
          rxTimer_q <= (rxTimer_q == LAST_TICK) ? 16'h0000 : rxTimer_q + 16'h0001;
          if (rxTimer_q == LAST_TICK) begin
            rxShift_q     <= rxShiftNext;
            rxBitIdx_q    <= rxBitIdx_q + 4'h1;
            rxNoiseSeen_q <= rxNoiseSeen_q | rxNoisy;
            if (!rxActive || rxDone || (rxBitIdx_q == 4'h0 && rxBit)) begin
              rxState_q <= RX_IDLE;
            end
          end
        end
        default: rxState_q <= RX_IDLE;
      endcase
    end
  end

  // Idle line counting in bit times of continuous ones
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      quietTimer_q <= 16'h0000;
      quietCnt_q   <= 4'h0;
    end else if (!rxActive || !rxSync_q || (idleAfterStop && rxState_q == RX_BITS)) begin
      quietTimer_q <= 16'h0000;
      quietCnt_q   <= 4'h0;
    end else begin
      quietTimer_q <= (quietTimer_q == LAST_TICK) ? 16'h0000 : quietTimer_q + 16'h0001;
      if (quietTimer_q == LAST_TICK && quietCnt_q != charLen) begin
        quietCnt_q <= quietCnt_q + 4'h1;
      end
    end
  end

  assign quietHit  = (quietTimer_q == LAST_TICK) & (quietCnt_q == charLen - 4'h1) & rxActive;
  assign wakeEvent = rxStandby_q & ((rouseSel & rxDone & topBit) | (~rouseSel & quietHit));

  // Status flags: hardware set wins over software clear, except overrun, which is not set in a cycle that clears the flags
  logic quietArmed_q, rxClear, rxStore;

  assign rxClear = rdData & statusSeen_q;
  assign rxStore = rxDone & (~rxStandby_q | (rouseSel & topBit)) & ~rxFull_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      statusSeen_q <= 1'b0;
    end else if (rdStatus) begin
      statusSeen_q <= 1'b1;
    end else if (rdData) begin
      statusSeen_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {rxFull_q, quiet_q, overrun_q, noise_q, frameErr_q, parityErr_q} <= 6'h00;
      quietArmed_q <= 1'b0;
    end else begin
      if (rxClear) begin
        {rxFull_q, quiet_q, overrun_q, noise_q, frameErr_q, parityErr_q} <= 6'h00;
      end
      if (rxStore) begin
        rxFull_q     <= 1'b1;
        quietArmed_q <= 1'b1;
        noise_q      <= noise_q | rxNoiseSeen_q | rxNoisy;
        frameErr_q   <= frameErr_q | ~rxBit;
        parityErr_q  <= parityErr_q | parErr;
      end
      if (rxDone && !rxStandby_q && rxFull_q && !rxClear) begin
        overrun_q <= 1'b1;
      end
      if (quietHit && !rxStandby_q && quietArmed_q) begin
        quiet_q      <= 1'b1;
        quietArmed_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rxStore) begin
      rxData_q  <= rxWord[7:0];
      rxNinth_q <= topBit;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txEmpty_q <= 1'b1;
      txDone_q  <= 1'b1;
    end else begin
      if (wrData) begin
        txEmpty_q <= 1'b0;
      end
      if (txLoadData || !moduleOn) begin
        txEmpty_q <= 1'b1;
      end
      txDone_q <= !moduleOn || (txEmpty_q && txState_q == TX_IDLE && !txLoadPre && !txLoadBreak);
    end
  end

  // Interrupt request outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txIrq_q  <= 1'b0;
      rxIrq_q  <= 1'b0;
      errIrq_q <= 1'b0;
    end else begin
      txIrq_q  <= moduleOn & ((txEmpty_q & txEmptyIrqEn_q) | (txDone_q & txDoneIrqEn_q));
      rxIrq_q  <= ~rxStandby_q & ((rxFull_q & rxFullIrqEn_q) | (quiet_q & quietIrqEn_q));
      errIrq_q <= |({overrun_q, noise_q, frameErr_q, parityErr_q} & errIrqEn_q);
    end
  end

  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = datOut_q;
  assign serialOutPin = serialOut_q;
  assign txIrq        = txIrq_q;
  assign rxIrq        = rxIrq_q;
  assign errIrq       = errIrq_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence markWake_s;
    rxDone && rxStandby_q && rouseSel && topBit && !wrTwo;
  endsequence

  sequence quietWake_s;
    quietHit && rxStandby_q && !rouseSel && !wrTwo;
  endsequence

  a_tx_irq_gate: assert property (!txEmptyIrqEn_q && !txDoneIrqEn_q && !wrTwo |=> !txIrq)
    else $error("transmit request without enable");
  a_rx_irq_standby: assert property (rxStandby_q |=> !rxIrq)
    else $error("receive request during standby");
  a_err_irq_cause: assert property ($rose(errIrq) |-> $past(|({overrun_q, noise_q, frameErr_q, parityErr_q} & errIrqEn_q)))
    else $error("error request without enabled flag");
  a_preamble_ones: assert property (txState_q == TX_SHIFT && txIsPre_q |=> serialOutPin)
    else $error("preamble bit not one");
  a_break_zeros: assert property (txState_q == TX_SHIFT && txIsBreak_q |=> !serialOutPin)
    else $error("break bit not zero");
  a_idle_high: assert property (txState_q == TX_IDLE ##1 txState_q == TX_IDLE |=> serialOutPin)
    else $error("line not idle high");
  a_mark_wake: assert property (markWake_s |=> !rxStandby_q && rxFull_q)
    else $error("address mark wake failed");
  a_quiet_wake: assert property (quietWake_s |=> !rxStandby_q && !$rose(quiet_q) && !$rose(rxFull_q))
    else $error("idle wake misbehaved");
  a_module_off: assert property (!moduleOn ##1 !moduleOn |=> txDone_q && txEmpty_q && !txIrq)
    else $error("disabled module transmit flags");
  a_ninth_copy: assert property (rxStore |=> rxNinth_q == $past(topBit))
    else $error("received ninth bit wrong");

endmodule
`default_nettype wire

//--- include/serial_ctrl_pkg.sv
// Constants, register map and state types for the asynchronous serial control block
package serial_ctrl_pkg;

  localparam logic [7:0] ADDR_CTRL_ONE   = 8'h10;
  localparam logic [7:0] ADDR_CTRL_TWO   = 8'h14;
  localparam logic [7:0] ADDR_CTRL_THREE = 8'h18;
  localparam logic [7:0] ADDR_STATUS     = 8'h1C;
  localparam logic [7:0] ADDR_DATA       = 8'h20;

  // Control one fields
  localparam int C1_MODULE_ON = 6;
  localparam int C1_CHAR_NINE = 4;
  localparam int C1_ROUSE_SEL = 3;
  localparam int C1_IDLE_SEL  = 2;
  localparam int C1_PARITY_ON = 1;
  localparam int C1_ODD_PAR   = 0;

  // Control two fields
  localparam int C2_TXE_IE  = 7;
  localparam int C2_TXD_IE  = 6;
  localparam int C2_RXF_IE  = 5;
  localparam int C2_QUIET_IE = 4;
  localparam int C2_TX_ON   = 3;
  localparam int C2_RX_ON   = 2;
  localparam int C2_STANDBY = 1;
  localparam int C2_BREAK   = 0;

  // Control three fields
  localparam int C3_RX_NINTH = 7;
  localparam int C3_TX_NINTH = 6;
  localparam int C3_OVR_IE   = 3;
  localparam int C3_NOISE_IE = 2;
  localparam int C3_FRAME_IE = 1;
  localparam int C3_PAR_IE   = 0;

  // Status fields
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_TX_DONE  = 6;
  localparam int ST_RX_FULL  = 5;
  localparam int ST_QUIET    = 4;
  localparam int ST_OVERRUN  = 3;
  localparam int ST_NOISE    = 2;
  localparam int ST_FRAME    = 1;
  localparam int ST_PARITY   = 0;

  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [3:0]  LEN_EIGHT    = 4'hA;
  localparam logic [3:0]  LEN_NINE     = 4'hB;
  localparam logic [10:0] FRAME_ONES   = 11'h7FF;
  localparam logic [10:0] FRAME_ZEROS  = 11'h000;
  localparam int unsigned BIT_CYCLES_DEF = 16;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'h0,
    TX_SHIFT = 2'h1,
    TX_MARK  = 2'h3
  } txState_e;

  typedef enum logic {
    RX_IDLE = 1'h0,
    RX_BITS = 1'h1
  } rxState_e;

endpackage

//--- verification/serial_node.sv
// Remote serial node: sends frames to the block and captures frames from it
`timescale 1ns/10ps
`default_nettype none
module serial_node #(
  parameter int unsigned BC = 8
)(
  input  wire logic        clk,
  input  wire logic        rxLine,
  output logic             txLine,
  input  wire logic        go,
  input  wire logic [10:0] frame,
  input  wire logic [3:0]  len,
  output logic      [10:0] seen,
  output logic             done
);
  logic [10:0] sh_q;
  logic [3:0]  left_q = 4'h0;
  logic [3:0]  idx_q;
  logic [7:0]  tc_q, rc_q;
  logic        busy_q = 1'b0;
  logic        prev_q = 1'b1;
  // Frames go out LSB first, one bit per BC cycles; line idles high between them
  assign txLine = (left_q != 4'h0) ? sh_q[0] : 1'b1;
  always_ff @(posedge clk) begin
    if (go) begin
      sh_q   <= frame;
      left_q <= len;
      tc_q   <= 8'h00;
    end else if (left_q != 4'h0) begin
      tc_q <= (tc_q == 8'(BC - 1)) ? 8'h00 : tc_q + 8'h01;
      if (tc_q == 8'(BC - 1)) begin
        sh_q   <= sh_q >> 1;
        left_q <= left_q - 4'h1;
      end
    end
  end
  // Capture starts on a falling edge, samples at mid-bit
  always_ff @(posedge clk) begin
    prev_q <= rxLine;
    done   <= 1'b0;
    if (!busy_q && prev_q && !rxLine) begin
      busy_q <= 1'b1;
      rc_q   <= 8'(BC / 2);
      idx_q  <= 4'h0;
      seen   <= 11'h7FF;
    end else if (busy_q) begin
      rc_q <= (rc_q == 8'(BC - 1)) ? 8'h00 : rc_q + 8'h01;
      if (rc_q == 8'(BC - 1)) begin
        seen[idx_q] <= rxLine;
        idx_q       <= idx_q + 4'h1;
        busy_q      <= (idx_q != len - 4'h1);
        done        <= (idx_q == len - 4'h1);
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the serial control block
`timescale 1ns/10ps
`default_nettype none
module tb
  import serial_ctrl_pkg::*;
;
  localparam int BC = 8;
  logic        clk = 1'b0;
  logic        sysRst, cyc, stb, we, go, ack, txPin, rxPin, txIrq, rxIrq, errIrq, done;
  logic [7:0]  adr, q, c1, c2, d;
  logic [3:0]  sel, len;
  logic [31:0] din, dout;
  logic [10:0] frame, seen;
  int          bad_count = 0;
  int          checked = 0;
  int          ticks = 0;
  int          n;

  async_serial_control_regs #(.BIT_CYCLES(BC)) dut_u (
    .clk(clk), .sys_rst(sysRst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(din), .wb_dat_o(dout), .wb_ack_o(ack), .serialInPin(rxPin),
    .serialOutPin(txPin), .txIrq(txIrq), .rxIrq(rxIrq), .errIrq(errIrq));
  serial_node #(.BC(BC)) node_u (.clk(clk), .rxLine(txPin), .txLine(rxPin), .go(go),
    .frame(frame), .len(len), .seen(seen), .done(done));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [10:0] got, input logic [10:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Classic single Wishbone cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    din <= {24'h00_0000, wd};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) bad_count++;
    q = dout[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic send(input logic [10:0] f);
    frame <= f;
    go    <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (12 * BC + 8) @(posedge clk);
  endtask

  task automatic wait_done();
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
  endtask

  function automatic logic [10:0] txFrame(input logic [7:0] cfg, input logic [7:0] dv, input logic t8);
    logic p;
    p = cfg[C1_ODD_PAR];
    if (cfg[C1_CHAR_NINE]) return {1'b1, cfg[C1_PARITY_ON] ? ^dv ^ p : t8, dv, 1'b0};
    return {2'b11, cfg[C1_PARITY_ON] ? ^dv[6:0] ^ p : dv[7], dv[6:0], 1'b0};
  endfunction

  always @(posedge clk) begin
    ticks++;
    if (ticks == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    sysRst = 1'b1;
    cyc    = 1'b0;
    stb    = 1'b0;
    we     = 1'b0;
    adr    = 8'h00;
    din    = 32'h0000_0000;
    sel    = 4'h1;
    go     = 1'b0;
    len    = LEN_EIGHT;
    frame  = 11'h7FF;
    void'($urandom(4));
    repeat (4) @(posedge clk);
    sysRst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, ADDR_CTRL_ONE + 8'(4 * i), 8'h00);
      check(q & (i == 2 ? 8'h0F : 8'hFF), i == 3 ? 8'hC0 : CTRL_RESET);
    end
    check({txPin, txIrq, rxIrq, errIrq}, 4'h8);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      c1 = 8'($urandom) & 8'h5F;
      c2 = 8'($urandom) & 8'hF2;
      d  = 8'($urandom) & 8'h4F;
      bus(1'b1, ADDR_CTRL_ONE, c1);
      bus(1'b1, ADDR_CTRL_TWO, c2);
      bus(1'b1, ADDR_CTRL_THREE, d);
      bus(1'b0, ADDR_CTRL_ONE, 8'h00);
      check(q, c1);
      bus(1'b0, ADDR_CTRL_TWO, 8'h00);
      check(q, c2 & 8'hF2);
      bus(1'b0, ADDR_CTRL_THREE, 8'h00);
      check(q & 8'h4F, d);
      check({txIrq, rxIrq, errIrq}, {c1[C1_MODULE_ON] & (c2[7] | c2[6]), 2'b00});
    end
    bus(1'b0, 8'h24, 8'h00);
    check(q, 8'h00);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      c1  = 8'h40 | (m[1] ? 8'h10 : 8'h00) | (m[0] ? 8'h02 : 8'h00) | 8'($urandom & 1);
      c2  = 8'($urandom) & 8'h40;
      d   = 8'($urandom);
      len = m[1] ? LEN_NINE : LEN_EIGHT;
      bus(1'b1, ADDR_CTRL_ONE, c1);
      bus(1'b1, ADDR_CTRL_THREE, c2);
      bus(1'b1, ADDR_CTRL_TWO, 8'h48);
      bus(1'b1, ADDR_DATA, d);
      n = 0;
      while (txPin !== 1'b0 && n < 400) begin
        @(posedge clk);
        n++;
      end
      check(n >= len * BC - 6 && n <= len * BC + 2, 1'b1);
      check(txIrq, 1'b0);
      wait_done();
      check(seen, txFrame(c1, d, c2[6]));
      repeat (2 * BC) @(posedge clk);
      check(txIrq, 1'b1);
      bus(1'b1, ADDR_CTRL_TWO, 8'h00);
      check(txPin, 1'b1);
    end
    $display("test transmit done");
    len = LEN_EIGHT;
    bus(1'b1, ADDR_CTRL_ONE, 8'h40);
    bus(1'b1, ADDR_CTRL_TWO, 8'h09);
    bus(1'b1, ADDR_CTRL_TWO, 8'h08);
    wait_done();
    check(seen, 11'h400);
    repeat (BC) @(posedge clk);
    check(txPin, 1'b1);
    $display("test break done");
    bus(1'b1, ADDR_CTRL_TWO, 8'h24);
    bus(1'b1, ADDR_CTRL_THREE, 8'h02);
    for (int k = 0; k < 2; k++) begin
      d = 8'($urandom);
      send({1'b1, k == 0, d, 1'b0});
      check(rxIrq, 1'b1);
      check(errIrq, k == 1);
      bus(1'b0, ADDR_STATUS, 8'h00);
      check(q & 8'h22, k[0] ? 8'h22 : 8'h20);
      bus(1'b0, ADDR_DATA, 8'h00);
      check(q, d);
      bus(1'b0, ADDR_CTRL_THREE, 8'h00);
      check(q[7], d[7]);
      check({rxIrq, errIrq}, 2'b00);
    end
    $display("test receive done");
    bus(1'b1, ADDR_CTRL_ONE, 8'h48);
    bus(1'b1, ADDR_CTRL_TWO, 8'h26);
    send({2'b11, 8'h35, 1'b0});
    check(rxIrq, 1'b0);
    send({2'b11, 8'hB5, 1'b0});
    check(rxIrq, 1'b1);
    bus(1'b0, ADDR_CTRL_TWO, 8'h00);
    check(q, 8'h24);
    $display("test standby done");
    stop_test();
  end
endmodule
`default_nettype wire
